// ==== logic/intc_map.vh ====
// Register map, field positions and reset values of the interrupt unit
`ifndef INTC_MAP_VH
`define INTC_MAP_VH
// Register indices on the 4-bit address port
`define OFS_MAIN 4'h0
`define OFS_EDGE_PRIO 4'h1
`define OFS_EXT_CTRL 4'h2
`define OFS_FLAGS1 4'h3
`define OFS_FLAGS2 4'h4
`define OFS_FLAGS3 4'h5
`define OFS_PEN1 4'h6
`define OFS_PEN2 4'h7
`define OFS_PEN3 4'h8
`define OFS_PPRI1 4'h9
`define OFS_PPRI2 4'hA
`define OFS_PPRI3 4'hB
`define OFS_PRIO_CTRL 4'hC
// Implemented-bit masks, writable-bit masks and reset values
`define MASK_EDGE_PRIO 8'hF5
`define RST_EDGE_PRIO 8'hF5
`define MASK_EXT_CTRL 8'hDB
`define RST_EXT_CTRL 8'hC0
`define MASK_FLAGS1 8'h7F
`define WMASK_FLAGS1 8'h4F
`define MASK_FLAGS2 8'h95
`define MASK_FLAGS3 8'h1F
`define MASK_PRIO_CTRL 8'h80
`define RST_ZERO 8'h00
// Main control fields
`define B_MASTER 7
`define B_PERIPH 6
`define B_TA_EN 5
`define B_X0_EN 4
`define B_PC_EN 3
`define B_TA_FLAG 2
`define B_X0_FLAG 1
`define B_PC_FLAG 0
// Edge and priority fields
`define B_X0_EDGE 6
`define B_X1_EDGE 5
`define B_X2_EDGE 4
`define B_TA_PRI 2
`define B_PC_PRI 0
// External pin control fields
`define B_X2_PRI 7
`define B_X1_PRI 6
`define B_X2_EN 4
`define B_X1_EN 3
`define B_X2_FLAG 1
`define B_X1_FLAG 0
// Peripheral flag fields and the priority-level enable
`define B_RX_FULL 5
`define B_TX_EMPTY 4
`define B_PRIO_LEVELS 7
// Vector addresses
`define VEC_HIGH 24'h000008
`define VEC_LOW 24'h000018
`endif

// ==== logic/interrupt_flag_enable_unit.v ====
// Interrupt flag, enable, priority and vector logic of the core
`timescale 1ns/1ps
`include "intc_map.vh"

module interrupt_flag_enable_unit (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [3:0] addr,
  input wire [7:0] writeData,
  input wire writeStrobe,
  input wire readStrobe,
  output reg [7:0] readData,
  // External pins, asynchronous
  input wire [2:0] extPin,
  input wire [3:0] portHigh,
  // Peripheral events, one-cycle pulses on clk
  input wire timerAOverflow,
  input wire adcDone,
  input wire sspDone,
  input wire capcompAEvent,
  input wire timer2Match,
  input wire timerBOverflow,
  input wire oscFail,
  input wire eeWriteDone,
  input wire lowSupplyDetect,
  input wire capcompBEvent,
  input wire pwmBaseMatch,
  input wire ic3Event,
  input wire ic2Event,
  input wire ic1Capture,
  input wire motionTimerMatch,
  // Peripheral levels on clk
  input wire rxBufferFull,
  input wire txBufferEmpty,
  input wire capcompBPwmMode,
  input wire ic1Enabled,
  // Core handshake
  input wire intAck,
  input wire intReturn,
  output reg irqHigh,
  output reg irqLow,
  output reg [23:0] vectorAddr
);

  // ==========================================================
  // Helpers
  // Selected-edge detect on a synchronised pin
  function edgeSeen;
    input now;
    input prev;
    input risingSel;
    begin
      edgeSeen = risingSel ? (now & ~prev) : (~now & prev);
    end
  endfunction

  // Sticky flag update: a set event wins over a software clear
  function [7:0] stickyNext;
    input [7:0] cur;
    input wrHit;
    input [7:0] wdata;
    input [7:0] wmask;
    input [7:0] setEv;
    begin
      stickyNext = (wrHit ? ((cur & ~wmask) | (wdata & wmask)) : cur) | setEv;
    end
  endfunction

  // ==========================================================
  // Registers
  reg [7:0] mainReg;
  reg [7:0] edgePrioReg;
  reg [7:0] extCtrlReg;
  reg [7:0] flags1Reg;
  reg [7:0] flags2Reg;
  reg [7:0] flags3Reg;
  reg [7:0] penReg [0:2];
  reg [7:0] ppriReg [0:2];
  reg [7:0] prioCtrlReg;
  reg servHighReg;
  reg servLowReg;
  reg [7:0] mainNext;
  reg [7:0] flags1Next;
  reg servHighNext;
  reg servLowNext;

  // Pin synchronisers and history
  reg [2:0] extMeta;
  reg [2:0] extSync;
  reg [2:0] extPrev;
  reg [3:0] portMeta;
  reg [3:0] portSync;
  reg [3:0] portPrev;
  reg pinsPrimed;
  reg [1:0] primeShift;

  wire priorityMode;
  wire [2:0] extEdge;
  wire portChange;
  wire [7:0] flags1Ev;
  wire [7:0] flags2Ev;
  wire [7:0] flags3Ev;
  wire [7:0] extEv;
  wire [7:0] pend1;
  wire [7:0] pend2;
  wire [7:0] pend3;
  wire periphAny;
  wire periphHigh;
  wire periphLow;
  wire taReq;
  wire x0Req;
  wire pcReq;
  wire x1Req;
  wire x2Req;
  wire coreAny;
  wire coreHigh;
  wire coreLow;
  wire reqHigh;
  wire reqLow;
  wire wrMain;

  // ==========================================================
  // Pin capture
  // Two stages per pin; edges count only once history holds a real sample
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      primeShift <= 2'h0;
      extMeta <= 3'h0;
      extSync <= 3'h0;
      extPrev <= 3'h0;
      portMeta <= 4'h0;
      portSync <= 4'h0;
      portPrev <= 4'h0;
      pinsPrimed <= 1'b0;
    end else begin
      extMeta <= extPin;
      extSync <= extMeta;
      extPrev <= extSync;
      portMeta <= portHigh;
      portSync <= portMeta;
      portPrev <= portSync;
      primeShift <= {primeShift[0], 1'b1};
      pinsPrimed <= primeShift[1];
    end
  end

  assign extEdge[0] = pinsPrimed &
    edgeSeen(extSync[0], extPrev[0], edgePrioReg[`B_X0_EDGE]);
  assign extEdge[1] = pinsPrimed &
    edgeSeen(extSync[1], extPrev[1], edgePrioReg[`B_X1_EDGE]);
  assign extEdge[2] = pinsPrimed &
    edgeSeen(extSync[2], extPrev[2], edgePrioReg[`B_X2_EDGE]);
  assign portChange = pinsPrimed & (|(portSync ^ portPrev));

  // ==========================================================
  // Event vectors per flag register
  // compare match lands on capture-compare A
  assign flags1Ev = {1'b0, adcDone, 2'b00, sspDone, capcompAEvent,
                     timer2Match, timerBOverflow};
  // capture-compare B held off in PWM mode
  assign flags2Ev = {oscFail, 2'b00, eeWriteDone, 1'b0, lowSupplyDetect,
                     1'b0, capcompBEvent & ~capcompBPwmMode};
  // input capture 1 only while that channel is enabled
  assign flags3Ev = {3'b000, pwmBaseMatch, ic3Event, ic2Event,
                     ic1Capture & ic1Enabled, motionTimerMatch};
  assign extEv = {6'b000000, extEdge[2], extEdge[1]};

  // ==========================================================
  // Request combination
  // priority levels only under the enable bit
  assign priorityMode = prioCtrlReg[`B_PRIO_LEVELS];
  assign pend1 = flags1Reg & penReg[0];
  assign pend2 = flags2Reg & penReg[1];
  assign pend3 = flags3Reg & penReg[2];
  assign periphAny = |{pend1, pend2, pend3};
  assign periphHigh = |{pend1 & ppriReg[0], pend2 & ppriReg[1], pend3 & ppriReg[2]};
  assign periphLow = |{pend1 & ~ppriReg[0], pend2 & ~ppriReg[1], pend3 & ~ppriReg[2]};
  // timer A source gated by its enable
  assign taReq = mainReg[`B_TA_FLAG] & mainReg[`B_TA_EN];
  // pin 0 source gated by bit 4
  assign x0Req = mainReg[`B_X0_FLAG] & mainReg[`B_X0_EN];
  assign pcReq = mainReg[`B_PC_FLAG] & mainReg[`B_PC_EN];
  assign x1Req = extCtrlReg[`B_X1_FLAG] & extCtrlReg[`B_X1_EN];
  assign x2Req = extCtrlReg[`B_X2_FLAG] & extCtrlReg[`B_X2_EN];
  assign coreAny = taReq | x0Req | pcReq | x1Req | x2Req;
  // pin 0 has no priority bit and is always high
  assign coreHigh = x0Req | (taReq & edgePrioReg[`B_TA_PRI]) |
    (pcReq & edgePrioReg[`B_PC_PRI]) | (x1Req & extCtrlReg[`B_X1_PRI]) |
    (x2Req & extCtrlReg[`B_X2_PRI]);
  assign coreLow = (taReq & ~edgePrioReg[`B_TA_PRI]) |
    (pcReq & ~edgePrioReg[`B_PC_PRI]) | (x1Req & ~extCtrlReg[`B_X1_PRI]) |
    (x2Req & ~extCtrlReg[`B_X2_PRI]);
  // compat: master gates all, bit 6 gates peripherals
  // priority mode: bit 7 gates the high level
  assign reqHigh = priorityMode ?
    (mainReg[`B_MASTER] & (coreHigh | periphHigh)) :
    (mainReg[`B_MASTER] & (coreAny | (mainReg[`B_PERIPH] & periphAny)));
  // bit 6 gates the low level; held off while high is served
  assign reqLow = priorityMode & mainReg[`B_PERIPH] & ~servHighReg &
    (coreLow | periphLow);

  assign wrMain = writeStrobe & (addr == `OFS_MAIN);

  // ==========================================================
  // Main control next value
  always @* begin
    mainNext = wrMain ? writeData : mainReg;
    mainNext[`B_TA_FLAG] = mainNext[`B_TA_FLAG] | timerAOverflow;
    mainNext[`B_X0_FLAG] = mainNext[`B_X0_FLAG] | extEdge[0];
    mainNext[`B_PC_FLAG] = mainNext[`B_PC_FLAG] | portChange;
    servHighNext = servHighReg;
    servLowNext = servLowReg;
    // taking a request closes its own level
    if (intAck) begin
      if (irqHigh) begin
        mainNext[`B_MASTER] = 1'b0;
        servHighNext = 1'b1;
      end else if (irqLow) begin
        mainNext[`B_PERIPH] = 1'b0;
        servLowNext = 1'b1;
      end
    end else if (intReturn) begin
      // Return reopens the most recent level
      if (servHighReg) begin
        mainNext[`B_MASTER] = 1'b1;
        servHighNext = 1'b0;
      end else if (servLowReg) begin
        mainNext[`B_PERIPH] = 1'b1;
        servLowNext = 1'b0;
      end
    end
  end

  // Peripheral flag 1 next value
  always @* begin
    // timer B flag sticky through stickyNext
    flags1Next = stickyNext(flags1Reg, writeStrobe & (addr == `OFS_FLAGS1),
      writeData, `WMASK_FLAGS1, flags1Ev);
    // serial bits follow the buffer state only
    flags1Next[`B_RX_FULL] = rxBufferFull;
    flags1Next[`B_TX_EMPTY] = txBufferEmpty;
  end

  // ==========================================================
  // Register state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mainReg <= `RST_ZERO;
      edgePrioReg <= `RST_EDGE_PRIO;
      extCtrlReg <= `RST_EXT_CTRL;
      flags1Reg <= `RST_ZERO;
      flags2Reg <= `RST_ZERO;
      flags3Reg <= `RST_ZERO;
      penReg[0] <= `RST_ZERO;
      penReg[1] <= `RST_ZERO;
      penReg[2] <= `RST_ZERO;
      ppriReg[0] <= `MASK_FLAGS1;
      ppriReg[1] <= `MASK_FLAGS2;
      ppriReg[2] <= `MASK_FLAGS3;
      prioCtrlReg <= `RST_ZERO;
      servHighReg <= 1'b0;
      servLowReg <= 1'b0;
    end else begin
      mainReg <= mainNext;
      flags1Reg <= flags1Next;
      servHighReg <= servHighNext;
      servLowReg <= servLowNext;
      // pins 1 and 2 flags sticky, set wins over clear
      extCtrlReg <= stickyNext(extCtrlReg, writeStrobe & (addr == `OFS_EXT_CTRL),
        writeData, `MASK_EXT_CTRL, extEv);
      // low supply flag sticky until software clears
      flags2Reg <= stickyNext(flags2Reg, writeStrobe & (addr == `OFS_FLAGS2),
        writeData, `MASK_FLAGS2, flags2Ev);
      flags3Reg <= stickyNext(flags3Reg, writeStrobe & (addr == `OFS_FLAGS3),
        writeData, `MASK_FLAGS3, flags3Ev);
      if (writeStrobe) begin
        case (addr)
          `OFS_EDGE_PRIO: edgePrioReg <= writeData & `MASK_EDGE_PRIO;
          `OFS_PEN1: penReg[0] <= writeData & `MASK_FLAGS1;
          `OFS_PEN2: penReg[1] <= writeData & `MASK_FLAGS2;
          `OFS_PEN3: penReg[2] <= writeData & `MASK_FLAGS3;
          `OFS_PPRI1: ppriReg[0] <= writeData & `MASK_FLAGS1;
          `OFS_PPRI2: ppriReg[1] <= writeData & `MASK_FLAGS2;
          `OFS_PPRI3: ppriReg[2] <= writeData & `MASK_FLAGS3;
          `OFS_PRIO_CTRL: prioCtrlReg <= writeData & `MASK_PRIO_CTRL;
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Read port, data one cycle after the strobe
  // unimplemented positions are stored as zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      readData <= `RST_ZERO;
    end else if (readStrobe) begin
      case (addr)
        `OFS_MAIN: readData <= mainReg;
        `OFS_EDGE_PRIO: readData <= edgePrioReg;
        `OFS_EXT_CTRL: readData <= extCtrlReg;
        `OFS_FLAGS1: readData <= flags1Reg;
        `OFS_FLAGS2: readData <= flags2Reg;
        `OFS_FLAGS3: readData <= flags3Reg;
        `OFS_PEN1: readData <= penReg[0];
        `OFS_PEN2: readData <= penReg[1];
        `OFS_PEN3: readData <= penReg[2];
        `OFS_PPRI1: readData <= ppriReg[0];
        `OFS_PPRI2: readData <= ppriReg[1];
        `OFS_PPRI3: readData <= ppriReg[2];
        `OFS_PRIO_CTRL: readData <= prioCtrlReg;
        default: readData <= `RST_ZERO;
      endcase
    end else begin
      readData <= `RST_ZERO;
    end
  end

  // ==========================================================
  // Request outputs to the core
  // high level and compat mode use the high vector
  // Request drops the cycle after the ack so one ack is never counted twice
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irqHigh <= 1'b0;
      irqLow <= 1'b0;
      vectorAddr <= `VEC_HIGH;
    end else begin
      irqHigh <= reqHigh & ~intAck;
      irqLow <= reqLow & ~reqHigh & ~intAck;
      vectorAddr <= (reqLow & ~reqHigh) ? `VEC_LOW : `VEC_HIGH;
    end
  end

endmodule

// ==== test/core_model.sv ====
// Behavioural core that takes requests and returns from service
`timescale 1ns/1ps
// ==========
// Core model
module core_model (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Bench control
  input wire serviceEn,
  input wire [3:0] ackDelay,
  // Requests
  input wire irqHigh,
  input wire irqLow,
  // Handshake
  output reg intAck,
  output reg intReturn
);
  reg [3:0] waitCnt_reg;
  reg [2:0] svcCnt_reg;
  reg busy_reg;
  // Ack only a standing request, so a slow core never acks a dropped one
  // take request
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      intAck <= 1'b0;
      intReturn <= 1'b0;
      waitCnt_reg <= 4'h0;
      svcCnt_reg <= 3'h0;
      busy_reg <= 1'b0;
    end else begin
      intAck <= 1'b0;
      intReturn <= 1'b0;
      if (busy_reg) begin
        svcCnt_reg <= svcCnt_reg + 3'h1;
        if (svcCnt_reg == 3'h7) begin
          intReturn <= 1'b1;
          busy_reg <= 1'b0;
        end
      end else if (serviceEn && (irqHigh || irqLow) && !intAck) begin
        waitCnt_reg <= waitCnt_reg + 4'h1;
        if (waitCnt_reg == ackDelay) begin
          intAck <= 1'b1;
          busy_reg <= 1'b1;
          waitCnt_reg <= 4'h0;
        end
      end else begin
        waitCnt_reg <= 4'h0;
      end
    end
  end
endmodule

// ==== test/intc_checker_sva.sv ====
// Port checker for the interrupt flag and enable unit
`timescale 1ns/1ps
// ==========
// Checker
module intc_checker (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [3:0] addr,
  input wire readStrobe,
  input wire [7:0] readData,
  // Serial levels
  input wire rxBufferFull,
  input wire txBufferEmpty,
  // Core handshake
  input wire intAck,
  input wire intReturn,
  input wire irqHigh,
  input wire irqLow,
  input wire [23:0] vectorAddr
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Read data stands only after a read
  read_idle_zero_a: assert property (!$past(readStrobe) |-> readData == 8'h00)
    else $error("read data not idle");
  unmapped_read_a: assert property (readStrobe && addr > 4'hC |=> readData == 8'h00)
    else $error("unmapped read not zero");
  flags2_unimpl_a: assert property (readStrobe && addr == 4'h4 |=> (readData & 8'h6A) == 8'h00)
    else $error("unimplemented flag bit set");
  flags3_unimpl_a: assert property (readStrobe && addr == 4'h5 ##1 1'b1 |-> readData[7:5] == 3'h0)
    else $error("unimplemented flag bit set");
  // Serial flags follow their levels with two cycles of lag at the port
  serial_mirror_a: assert property (readStrobe && addr == 4'h3 |=>
    readData[5:4] == {$past(rxBufferFull, 2), $past(txBufferEmpty, 2)})
    else $error("serial flags wrong");
  vec_high_a: assert property (irqHigh |-> vectorAddr == 24'h000008)
    else $error("high vector wrong");
  vec_low_a: assert property (irqLow && !irqHigh |-> vectorAddr == 24'h000018)
    else $error("low vector wrong");
  ack_drop_a: assert property (intAck |=> !irqHigh && !irqLow)
    else $error("request held after ack");
  // Main scenarios reached
  cover property (irqHigh && intAck);
  cover property (irqLow && !irqHigh);
  cover property (intAck ##[1:20] intReturn);
endmodule

bind interrupt_flag_enable_unit intc_checker u_intc_checker (.clk(clk), .rst(rst),
  .addr(addr), .readStrobe(readStrobe), .readData(readData), .rxBufferFull(rxBufferFull),
  .txBufferEmpty(txBufferEmpty), .intAck(intAck), .intReturn(intReturn), .irqHigh(irqHigh),
  .irqLow(irqLow), .vectorAddr(vectorAddr));

// ==== test/testbench.sv ====
// Self-checking bench for the interrupt flag and enable unit
`timescale 1ns/1ps
// ==========
// Bench
module testbench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] addr = 4'h0;
  reg [7:0] writeData = 8'h00;
  reg writeStrobe = 1'b0;
  reg readStrobe = 1'b0;
  reg [2:0] extPin = 3'h0;
  reg [3:0] portHigh = 4'h0;
  reg [14:0] ev = 15'h0000;
  reg rxBufferFull = 1'b0;
  reg txBufferEmpty = 1'b0;
  reg capcompBPwmMode = 1'b0;
  reg ic1Enabled = 1'b0;
  reg serviceEn = 1'b0;
  reg [3:0] ackDelay = 4'h0;
  wire [7:0] readData;
  wire intAck, intReturn, irqHigh, irqLow;
  wire [23:0] vectorAddr;
  integer mismatches = 0;
  integer comparisons = 0;
  integer i;
  reg [7:0] resetVal [0:13];
  // Clock of 5 ns
  always #2.5 clk = ~clk;
  interrupt_flag_enable_unit u_interrupt_flag_enable_unit (.clk(clk), .rst(rst), .addr(addr),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData), .extPin(extPin), .portHigh(portHigh), .timerAOverflow(ev[0]),
    .adcDone(ev[1]), .sspDone(ev[2]), .capcompAEvent(ev[3]), .timer2Match(ev[4]),
    .timerBOverflow(ev[5]), .oscFail(ev[6]), .eeWriteDone(ev[7]), .lowSupplyDetect(ev[8]),
    .capcompBEvent(ev[9]), .pwmBaseMatch(ev[10]), .ic3Event(ev[11]), .ic2Event(ev[12]),
    .ic1Capture(ev[13]), .motionTimerMatch(ev[14]), .rxBufferFull(rxBufferFull),
    .txBufferEmpty(txBufferEmpty), .capcompBPwmMode(capcompBPwmMode), .ic1Enabled(ic1Enabled),
    .intAck(intAck), .intReturn(intReturn), .irqHigh(irqHigh), .irqLow(irqLow),
    .vectorAddr(vectorAddr));
  core_model u_core_model (.clk(clk), .rst(rst), .serviceEn(serviceEn), .ackDelay(ackDelay),
    .irqHigh(irqHigh), .irqLow(irqLow), .intAck(intAck), .intReturn(intReturn));
  // ==========
  // Shared tasks
  task chk(input [79:0] n, input [23:0] e, input [23:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("wrong value %0s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      writeStrobe <= 1'b1;
      addr <= a;
      writeData <= d;
      @(posedge clk);
      writeStrobe <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [7:0] e);
    begin
      @(posedge clk);
      readStrobe <= 1'b1;
      addr <= a;
      @(posedge clk);
      readStrobe <= 1'b0;
      // Data launched at the previous edge, read before this edge updates it
      @(posedge clk);
      chk("readData", {16'h0, e}, {16'h0, readData});
    end
  endtask
  task pulse(input integer n);
    begin
      @(posedge clk);
      ev[n] <= 1'b1;
      @(posedge clk);
      ev <= 15'h0000;
    end
  endtask
  task settle(input integer n);
    begin
      repeat (n) @(posedge clk);
    end
  endtask
  task irqs(input h, input l);
    begin
      settle(3);
      chk("irqHigh", {23'h0, h}, {23'h0, irqHigh});
      chk("irqLow", {23'h0, l}, {23'h0, irqLow});
    end
  endtask
  // Bounded wait for ack or return from the core
  task waitSig(input sel);
    integer k;
    begin
      k = 0;
      while (k < 60 && (sel ? intReturn : intAck) !== 1'b1) begin
        settle(1);
        k = k + 1;
      end
      chk("handshake", 24'h1, {23'h0, sel ? intReturn : intAck});
      @(posedge clk);
      serviceEn <= 1'b0;
    end
  endtask
  // ==========
  // Scenarios
  task s_reset;
    begin
      for (i = 0; i < 14; i = i + 1) rd(i, resetVal[i]);
      wr(4'hD, 8'hFF);
      rd(4'hD, 8'h00);
      wr(4'h1, 8'hFF);
      rd(4'h1, 8'hF5);
      wr(4'h2, 8'hFF);
      rd(4'h2, 8'hDB);
      wr(4'h2, 8'hC0);
    end
  endtask
  task s_flags;
    begin
      pulse(5);
      pulse(8);
      pulse(3);
      pulse(0);
      irqs(0, 0);
      rd(4'h3, 8'h05);
      rd(4'h4, 8'h04);
      rd(4'h0, 8'h04);
      capcompBPwmMode <= 1'b1;
      pulse(9);
      rd(4'h4, 8'h04);
      capcompBPwmMode <= 1'b0;
      pulse(13);
      rd(4'h5, 8'h00);
      ic1Enabled <= 1'b1;
      pulse(13);
      rd(4'h5, 8'h02);
      rxBufferFull <= 1'b1;
      txBufferEmpty <= 1'b1;
      wr(4'h3, 8'h00);
      rd(4'h3, 8'h30);
      rxBufferFull <= 1'b0;
      txBufferEmpty <= 1'b0;
      settle(2);
      rd(4'h3, 8'h00);
      wr(4'h0, 8'h00);
      wr(4'h4, 8'h00);
      wr(4'h5, 8'h00);
      rd(4'h4, 8'h00);
    end
  endtask
  task s_compat;
    begin
      wr(4'h0, 8'h20);
      pulse(0);
      irqs(0, 0);
      wr(4'h0, 8'hA4);
      irqs(1, 0);
      chk("vectorAddr", 24'h000008, vectorAddr);
      serviceEn <= 1'b1;
      waitSig(0);
      rd(4'h0, 8'h24);
      waitSig(1);
      rd(4'h0, 8'hA4);
      wr(4'h6, 8'h01);
      wr(4'h0, 8'h80);
      pulse(5);
      irqs(0, 0);
      wr(4'h0, 8'hC0);
      irqs(1, 0);
    end
  endtask
  task s_prio;
    begin
      wr(4'h9, 8'h7E);
      wr(4'hC, 8'h80);
      irqs(0, 1);
      chk("vectorAddr", 24'h000018, vectorAddr);
      ackDelay <= 4'h3;
      serviceEn <= 1'b1;
      waitSig(0);
      rd(4'h0, 8'h80);
      waitSig(1);
      rd(4'h0, 8'hC0);
      wr(4'h0, 8'h80);
      irqs(0, 0);
      wr(4'h0, 8'hA0);
      pulse(0);
      irqs(1, 0);
      wr(4'h0, 8'h00);
      wr(4'hC, 8'h00);
      wr(4'h3, 8'h00);
    end
  endtask
  task s_pins;
    begin
      extPin[0] <= 1'b1;
      settle(6);
      rd(4'h0, 8'h02);
      rd(4'h0, 8'h02);
      wr(4'h1, 8'hB5);
      wr(4'h0, 8'h90);
      extPin[0] <= 1'b0;
      // Sync chain and history delay the flag beyond the irqs window
      settle(2);
      irqs(1, 0);
      rd(4'h0, 8'h92);
      wr(4'h0, 8'h00);
      extPin[0] <= 1'b1;
      settle(6);
      rd(4'h0, 8'h00);
      portHigh <= 4'h4;
      settle(6);
      rd(4'h0, 8'h01);
    end
  endtask
  // ==========
  // Verdict
  task end_sim;
    begin
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    for (i = 0; i < 14; i = i + 1) resetVal[i] = 8'h00;
    resetVal[1] = 8'hF5;
    resetVal[2] = 8'hC0;
    resetVal[9] = 8'h7F;
    resetVal[10] = 8'h95;
    resetVal[11] = 8'h1F;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    s_reset;
    s_flags;
    s_compat;
    s_prio;
    s_pins;
    end_sim;
  end
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #50000;
    mismatches = mismatches + 1;
    end_sim;
  end
endmodule
